// ===== src/flash_erase_command_sequencer.sv
`timescale 1ns/100ps
// What this block does
// - launch block erase: erase, then verify
// - set command complete after verify finishes
// - access error when index not 001
// - access error when mode forbids command
// - access error on unmapped global address
// - access error on misaligned flash/eeprom address
// - protection violation on protected target block
// - upper verify bit on any verify error
// - lower verify bit on uncorrectable error
// - sector erase: erase, verify, complete
// - command irq: complete flag and enable
// - error irq: fault flag and enable
// - runs in wait; complete irq wakes
// - stop waits for running command
module flash_erase_command_sequencer #(
    parameter int ERASE_BLOCK_CYCLES  = nvm_seq_pkg::ERASE_BLOCK_CYC,
    parameter int ERASE_SECTOR_CYCLES = nvm_seq_pkg::ERASE_SECTOR_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    input  wire logic        verify_fail,
    input  wire logic        verify_uncorrectable,
    input  wire logic        stop_request,
    output logic             stop_ack,
    output logic             erase_active,
    output logic      [23:0] erase_addr,
    output logic             erase_sector,
    output logic             command_irq,
    output logic             error_irq,
    output logic             irq
);

    nvm_seq_pkg::seq_state_e state_reg;
    nvm_seq_pkg::command_s   cmd_reg;
    nvm_seq_pkg::erase_req_s req_reg;
    logic [7:0]  status_reg;
    logic [7:0]  config_reg;
    logic [2:0]  index_reg;
    logic [1:0]  protect_reg;
    logic [1:0]  irq_st_reg;
    logic [1:0]  irq_msk_reg;
    logic        mode_reg;
    logic        fault_reg;
    logic [31:0] count_reg;
    logic        vfail_reg;
    logic        vunc_reg;
    logic        launch;
    logic        addr_pf;
    logic        addr_ee;
    logic        acc_err;
    logic        prot_err;

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // write 1 to complete flag while set starts the command
    assign launch = reg_write && reg_addr == nvm_seq_pkg::ADDR_STATUS
                    && reg_wdata[nvm_seq_pkg::STAT_CCF]
                    && status_reg[nvm_seq_pkg::STAT_CCF];

    assign addr_pf = in_range(cmd_reg.addr, nvm_seq_pkg::PF_BASE, nvm_seq_pkg::PF_LAST);
    assign addr_ee = in_range(cmd_reg.addr, nvm_seq_pkg::EE_BASE, nvm_seq_pkg::EE_LAST);

    always_comb begin
        acc_err = 1'b0;
        if (index_reg != nvm_seq_pkg::INDEX_LAUNCH)
            acc_err = 1'b1;
        if (mode_reg)
            acc_err = 1'b1;
        // mapped address; sector erase only on flash
        if (!(addr_pf || (addr_ee && cmd_reg.code == nvm_seq_pkg::CMD_ERASE_BLOCK)))
            acc_err = 1'b1;
        if (addr_pf && cmd_reg.addr[nvm_seq_pkg::PF_PHRASE_BITS-1:0] != 3'h0)
            acc_err = 1'b1;
        if (addr_ee && cmd_reg.addr[0])
            acc_err = 1'b1;
        if (cmd_reg.code != nvm_seq_pkg::CMD_ERASE_BLOCK
            && cmd_reg.code != nvm_seq_pkg::CMD_ERASE_SECTOR)
            acc_err = 1'b1;
    end

    assign prot_err = (addr_pf && protect_reg[0]) || (addr_ee && protect_reg[1]);

    // command words, index selects which one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_reg   <= '0;
            index_reg <= 3'h0;
        end else if (reg_write && state_reg == nvm_seq_pkg::ST_IDLE) begin
            if (reg_addr == nvm_seq_pkg::ADDR_INDEX)
                index_reg <= reg_wdata[2:0];
            if (reg_addr == nvm_seq_pkg::ADDR_WORD && index_reg == 3'h0) begin
                cmd_reg.code       <= reg_wdata[15:8];
                cmd_reg.addr[23:16] <= reg_wdata[7:0];
            end
            if (reg_addr == nvm_seq_pkg::ADDR_WORD && index_reg == 3'h1)
                cmd_reg.addr[15:0] <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            config_reg  <= 8'h00;
            protect_reg <= 2'h0;
            irq_msk_reg <= 2'h0;
            mode_reg    <= 1'b0;
            fault_reg   <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == nvm_seq_pkg::ADDR_CONFIG)
                config_reg <= reg_wdata[7:0];
            if (reg_addr == nvm_seq_pkg::ADDR_PROTECT)
                protect_reg <= reg_wdata[1:0];
            if (reg_addr == nvm_seq_pkg::ADDR_IRQ_MSK)
                irq_msk_reg <= reg_wdata[1:0];
            if (reg_addr == nvm_seq_pkg::ADDR_MODE)
                mode_reg <= reg_wdata[0];
            if (reg_addr == nvm_seq_pkg::ADDR_FAULT)
                fault_reg <= reg_wdata[0];
        end
    end

    // sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= nvm_seq_pkg::ST_IDLE;
            req_reg   <= '0;
            count_reg <= 32'h0;
            vfail_reg <= 1'b0;
            vunc_reg  <= 1'b0;
        end else begin
            case (state_reg)
                nvm_seq_pkg::ST_IDLE: begin
                    if (launch)
                        state_reg <= nvm_seq_pkg::ST_CHECK;
                end
                nvm_seq_pkg::ST_CHECK: begin
                    vfail_reg <= 1'b0;
                    vunc_reg  <= 1'b0;
                    if (acc_err || prot_err) begin
                        state_reg <= nvm_seq_pkg::ST_DONE;
                    end else begin
                        // start erase of block or sector
                        req_reg.addr   <= cmd_reg.addr;
                        req_reg.sector <= cmd_reg.code == nvm_seq_pkg::CMD_ERASE_SECTOR;
                        count_reg <= (cmd_reg.code == nvm_seq_pkg::CMD_ERASE_SECTOR)
                                     ? 32'(ERASE_SECTOR_CYCLES) : 32'(ERASE_BLOCK_CYCLES);
                        state_reg <= nvm_seq_pkg::ST_ERASE;
                    end
                end
                nvm_seq_pkg::ST_ERASE: begin
                    if (count_reg <= 32'h1) begin
                        count_reg <= 32'(nvm_seq_pkg::VERIFY_CYC);
                        state_reg <= nvm_seq_pkg::ST_VERIFY;
                    end else begin
                        count_reg <= count_reg - 32'h1;
                    end
                end
                nvm_seq_pkg::ST_VERIFY: begin
                    if (verify_fail)
                        vfail_reg <= 1'b1;
                    if (verify_uncorrectable)
                        vunc_reg <= 1'b1;
                    if (count_reg <= 32'h1)
                        state_reg <= nvm_seq_pkg::ST_DONE;
                    else
                        count_reg <= count_reg - 32'h1;
                end
                nvm_seq_pkg::ST_DONE: begin
                    state_reg <= nvm_seq_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= nvm_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // status: complete flag plus error bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_reg <= 8'h80;
        end else if (launch) begin
            status_reg <= 8'h00;
        end else if (state_reg == nvm_seq_pkg::ST_CHECK) begin
            status_reg[nvm_seq_pkg::STAT_ACC]   <= acc_err;
            status_reg[nvm_seq_pkg::STAT_PVIOL] <= prot_err && !acc_err;
        end else if (state_reg == nvm_seq_pkg::ST_DONE) begin
            status_reg[nvm_seq_pkg::STAT_CCF] <= 1'b1;
            status_reg[nvm_seq_pkg::STAT_VS1] <= vfail_reg || vunc_reg;
            status_reg[nvm_seq_pkg::STAT_VS0] <= vunc_reg;
        end
    end

    // sticky events, read clears, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_st_reg <= 2'h0;
        end else begin
            if (reg_read && reg_addr == nvm_seq_pkg::ADDR_IRQ_ST)
                irq_st_reg <= 2'h0;
            if (state_reg == nvm_seq_pkg::ST_DONE)
                irq_st_reg[nvm_seq_pkg::IRQ_DONE] <= 1'b1;
            if (state_reg == nvm_seq_pkg::ST_CHECK && (acc_err || prot_err))
                irq_st_reg[nvm_seq_pkg::IRQ_ERR] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                nvm_seq_pkg::ADDR_STATUS:  reg_rdata <= {8'h00, status_reg};
                nvm_seq_pkg::ADDR_CONFIG:  reg_rdata <= {8'h00, config_reg};
                nvm_seq_pkg::ADDR_INDEX:   reg_rdata <= {13'h0000, index_reg};
                nvm_seq_pkg::ADDR_WORD:    reg_rdata <= (index_reg == 3'h0)
                                              ? {cmd_reg.code, cmd_reg.addr[23:16]}
                                              : cmd_reg.addr[15:0];
                nvm_seq_pkg::ADDR_PROTECT: reg_rdata <= {14'h0000, protect_reg};
                nvm_seq_pkg::ADDR_IRQ_ST:  reg_rdata <= {14'h0000, irq_st_reg};
                nvm_seq_pkg::ADDR_IRQ_MSK: reg_rdata <= {14'h0000, irq_msk_reg};
                nvm_seq_pkg::ADDR_MODE:    reg_rdata <= {15'h0000, mode_reg};
                nvm_seq_pkg::ADDR_FAULT:   reg_rdata <= {15'h0000, fault_reg};
                default:                   reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // outputs, all registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            command_irq  <= 1'b0;
            error_irq    <= 1'b0;
            irq          <= 1'b0;
            stop_ack     <= 1'b0;
            erase_active <= 1'b0;
            erase_addr   <= 24'h000000;
            erase_sector <= 1'b0;
        end else begin
            // command irq, also wakes from wait
            command_irq <= status_reg[nvm_seq_pkg::STAT_CCF] && config_reg[nvm_seq_pkg::CFG_COMMAND_COMPLETE_IRQ_ENABLE];
            error_irq <= fault_reg && config_reg[nvm_seq_pkg::CFG_SINGLE_FAULT_DETECT_IRQ_ENABLE];
            irq <= |(irq_st_reg & irq_msk_reg);
            stop_ack <= stop_request && status_reg[nvm_seq_pkg::STAT_CCF] && !launch
                        && state_reg == nvm_seq_pkg::ST_IDLE;
            erase_active <= state_reg == nvm_seq_pkg::ST_ERASE;
            erase_addr   <= req_reg.addr;
            erase_sector <= req_reg.sector;
        end
    end

    a_stop_when_busy: assert property (@(posedge clk_sys) disable iff (rst)
        !status_reg[nvm_seq_pkg::STAT_CCF] |=> !stop_ack)
        else $error("stop granted during command");

    a_done_after_verify: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == nvm_seq_pkg::ST_VERIFY && count_reg == 32'h1
        |=> ##1 status_reg[nvm_seq_pkg::STAT_CCF])
        else $error("complete flag late");

    // launch error goes straight to done
    a_error_skips_erase: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == nvm_seq_pkg::ST_CHECK && (acc_err || prot_err)
        |=> state_reg == nvm_seq_pkg::ST_DONE ##1 status_reg[nvm_seq_pkg::STAT_CCF])
        else $error("erase not skipped");

    a_index_error: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == nvm_seq_pkg::ST_CHECK && index_reg != nvm_seq_pkg::INDEX_LAUNCH
        |=> status_reg[nvm_seq_pkg::STAT_ACC])
        else $error("index error missed");

    // command irq follows flag and enable
    a_cmd_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
        command_irq == $past(status_reg[nvm_seq_pkg::STAT_CCF]
                             && config_reg[nvm_seq_pkg::CFG_COMMAND_COMPLETE_IRQ_ENABLE]))
        else $error("command irq wrong");

    a_erase_then_verify: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == nvm_seq_pkg::ST_VERIFY |-> $past(state_reg) inside
            {nvm_seq_pkg::ST_ERASE, nvm_seq_pkg::ST_VERIFY})
        else $error("verify without erase");

    a_verify_bits: assert property (@(posedge clk_sys) disable iff (rst)
        status_reg[nvm_seq_pkg::STAT_VS0] |-> status_reg[nvm_seq_pkg::STAT_VS1])
        else $error("verify bits inconsistent");

    a_protect_flag: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == nvm_seq_pkg::ST_CHECK && prot_err && !acc_err
        |=> status_reg[nvm_seq_pkg::STAT_PVIOL] && state_reg == nvm_seq_pkg::ST_DONE)
        else $error("protection violation missed");

    // error irq set one cycle after flag and enable
    a_error_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
        fault_reg && config_reg[nvm_seq_pkg::CFG_SINGLE_FAULT_DETECT_IRQ_ENABLE] |=> error_irq)
        else $error("error irq missing");

    a_stop_granted: assert property (@(posedge clk_sys) disable iff (rst)
        stop_request && status_reg[nvm_seq_pkg::STAT_CCF] && !launch
        && state_reg == nvm_seq_pkg::ST_IDLE |=> stop_ack)
        else $error("stop not granted");

    a_erase_starts: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == nvm_seq_pkg::ST_CHECK && !(acc_err || prot_err)
        |=> ##1 erase_active)
        else $error("erase phase missing");

    a_launch_clears: assert property (@(posedge clk_sys) disable iff (rst)
        launch |=> !status_reg[nvm_seq_pkg::STAT_CCF] && state_reg == nvm_seq_pkg::ST_CHECK)
        else $error("launch not taken");

endmodule

// ===== src/nvm_seq_pkg.sv
package nvm_seq_pkg;

    // register offsets of the command sequencer
    localparam logic [3:0] ADDR_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_CONFIG  = 4'h1;
    localparam logic [3:0] ADDR_INDEX   = 4'h2;
    localparam logic [3:0] ADDR_WORD    = 4'h3;
    localparam logic [3:0] ADDR_PROTECT = 4'h4;
    localparam logic [3:0] ADDR_IRQ_ST  = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MSK = 4'h6;
    localparam logic [3:0] ADDR_MODE    = 4'h7;
    localparam logic [3:0] ADDR_FAULT   = 4'h8;

    // status register fields
    localparam int STAT_CCF   = 7;
    localparam int STAT_ACC   = 5;
    localparam int STAT_PVIOL = 4;
    localparam int STAT_VS1   = 1;
    localparam int STAT_VS0   = 0;

    // config register fields
    localparam int CFG_COMMAND_COMPLETE_IRQ_ENABLE  = 7;
    localparam int CFG_SINGLE_FAULT_DETECT_IRQ_ENABLE = 4;

    // irq status bits: done, error
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;

    localparam logic [7:0] CMD_ERASE_BLOCK  = 8'h09;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0a;
    localparam logic [2:0] INDEX_LAUNCH     = 3'h1;

    // memory map: flash block, eeprom block
    localparam logic [23:0] PF_BASE  = 24'hff8000;
    localparam logic [23:0] PF_LAST  = 24'hffffff;
    localparam logic [23:0] EE_BASE  = 24'h100000;
    localparam logic [23:0] EE_LAST  = 24'h1001ff;
    localparam int          PF_PHRASE_BITS = 3;
    localparam int          SECTOR_BITS    = 9;

    // erase timing
    localparam int CLK_MHZ           = 20;
    localparam int ERASE_BLOCK_US    = 200;
    localparam int ERASE_SECTOR_US   = 20;
    localparam int ERASE_BLOCK_CYC   = ERASE_BLOCK_US * CLK_MHZ;
    localparam int ERASE_SECTOR_CYC  = ERASE_SECTOR_US * CLK_MHZ;
    localparam int VERIFY_CYC        = 16;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CHECK  = 3'b001,
        ST_ERASE  = 3'b010,
        ST_VERIFY = 3'b011,
        ST_DONE   = 3'b100
    } seq_state_e;

    typedef struct packed {
        logic [7:0]  code;
        logic [23:0] addr;
    } command_s;

    typedef struct packed {
        logic [23:0] addr;
        logic        sector;
    } erase_req_s;

endpackage

// ===== tb/flash_array_model.sv
`timescale 1ns/100ps
module flash_array_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        erase_active,
    input  wire logic [23:0] erase_addr,
    input  wire logic        erase_sector,
    input  wire logic        inject_fail,
    input  wire logic        inject_uncorr,
    output logic             verify_fail,
    output logic             verify_uncorrectable,
    output int               erase_count,
    output logic      [23:0] last_addr,
    output logic             last_sector
);
    logic active_reg;

    // each rising erase phase counts one erase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            active_reg  <= 1'b0;
            erase_count <= 0;
            last_addr   <= 24'h000000;
            last_sector <= 1'b0;
        end else begin
            active_reg <= erase_active;
            if (erase_active && !active_reg) begin
                erase_count <= erase_count + 1;
                last_addr   <= erase_addr;
                last_sector <= erase_sector;
            end
        end
    end

    // verify result only reported outside the erase phase
    assign verify_fail          = inject_fail && !erase_active;
    assign verify_uncorrectable = inject_uncorr && !erase_active;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    typedef struct {
        logic [7:0]  code;
        logic [23:0] addr;
        logic [2:0]  idx;
        logic        mode;
        logic [1:0]  prot;
        logic [7:0]  stat;
        logic        erase;
    } row_s;
    localparam int NROWS = 11;
    row_s rows [NROWS] = '{
        '{8'h09, 24'hff8000, 3'h1, 1'b0, 2'h0, 8'h80, 1'b1},
        '{8'h0a, 24'hffa200, 3'h1, 1'b0, 2'h0, 8'h80, 1'b1},
        '{8'h09, 24'h100000, 3'h1, 1'b0, 2'h0, 8'h80, 1'b1},
        '{8'h09, 24'hff8000, 3'h0, 1'b0, 2'h0, 8'ha0, 1'b0},
        '{8'h09, 24'hff8000, 3'h1, 1'b1, 2'h0, 8'ha0, 1'b0},
        '{8'h09, 24'h200000, 3'h1, 1'b0, 2'h0, 8'ha0, 1'b0},
        '{8'h09, 24'hff8004, 3'h1, 1'b0, 2'h0, 8'ha0, 1'b0},
        '{8'h09, 24'h100001, 3'h1, 1'b0, 2'h0, 8'ha0, 1'b0},
        '{8'h09, 24'hff8000, 3'h1, 1'b0, 2'h1, 8'h90, 1'b0},
        '{8'h0a, 24'h100000, 3'h1, 1'b0, 2'h0, 8'ha0, 1'b0},
        '{8'h0a, 24'hff8000, 3'h1, 1'b0, 2'h2, 8'h80, 1'b1}
    };
    logic        clk_sys;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [15:0] reg_rdata;
    logic        verify_fail;
    logic        verify_uncorrectable;
    logic        stop_request;
    logic        stop_ack;
    logic        erase_active;
    logic [23:0] erase_addr;
    logic        erase_sector;
    logic        command_irq;
    logic        error_irq;
    logic        irq;
    logic        inject_fail;
    logic        inject_uncorr;
    logic [23:0] last_addr;
    logic        last_sector;
    logic [15:0] rd_val;
    int          erase_count;
    int          base;
    int          fails;
    int          cmp_count;

    flash_erase_command_sequencer #(
        .ERASE_BLOCK_CYCLES  (12),
        .ERASE_SECTOR_CYCLES (6)
    ) dut (
        .clk_sys              (clk_sys),
        .rst                  (rst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_write            (reg_write),
        .reg_read             (reg_read),
        .reg_rdata            (reg_rdata),
        .verify_fail          (verify_fail),
        .verify_uncorrectable (verify_uncorrectable),
        .stop_request         (stop_request),
        .stop_ack             (stop_ack),
        .erase_active         (erase_active),
        .erase_addr           (erase_addr),
        .erase_sector         (erase_sector),
        .command_irq          (command_irq),
        .error_irq            (error_irq),
        .irq                  (irq)
    );

    flash_array_model model (
        .clk_sys              (clk_sys),
        .rst                  (rst),
        .erase_active         (erase_active),
        .erase_addr           (erase_addr),
        .erase_sector         (erase_sector),
        .inject_fail          (inject_fail),
        .inject_uncorr        (inject_uncorr),
        .verify_fail          (verify_fail),
        .verify_uncorrectable (verify_uncorrectable),
        .erase_count          (erase_count),
        .last_addr            (last_addr),
        .last_sector          (last_sector)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk(name, {15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic launch(input row_s r);
        wr(nvm_seq_pkg::ADDR_MODE, {15'h0000, r.mode});
        wr(nvm_seq_pkg::ADDR_PROTECT, {14'h0000, r.prot});
        wr(nvm_seq_pkg::ADDR_INDEX, 16'h0000);
        wr(nvm_seq_pkg::ADDR_WORD, {r.code, r.addr[23:16]});
        wr(nvm_seq_pkg::ADDR_INDEX, 16'h0001);
        wr(nvm_seq_pkg::ADDR_WORD, r.addr[15:0]);
        wr(nvm_seq_pkg::ADDR_INDEX, {13'h0000, r.idx});
        wr(nvm_seq_pkg::ADDR_STATUS, 16'h0080);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        rd_val = 16'h0000;
        while (rd_val[7] !== 1'b1 && n < 200) begin
            rd(nvm_seq_pkg::ADDR_STATUS, rd_val);
            n++;
        end
        chk_bit("complete flag", 1'b1, rd_val[7]);
    endtask

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    initial begin
        #1_000_000;
        fails++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        stop_request = 1'b0;
        inject_fail = 1'b0;
        inject_uncorr = 1'b0;
        fails = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(nvm_seq_pkg::ADDR_STATUS, rd_val);
        chk("status after reset", 16'h0080, rd_val);
        chk("irq lines after reset", 16'h0000, {13'h0000, command_irq, error_irq, irq});
        for (int i = 0; i < NROWS; i++) begin
            base = erase_count;
            launch(rows[i]);
            wait_done();
            chk("status", {8'h00, rows[i].stat}, {8'h00, rd_val[7:0]});
            chk_bit("erase done", rows[i].erase, erase_count != base);
            if (rows[i].erase) begin
                chk("erase target", {7'h00, rows[i].code == nvm_seq_pkg::CMD_ERASE_SECTOR,
                    rows[i].addr[23:16]}, {7'h00, last_sector, last_addr[23:16]});
                chk("erase low address", rows[i].addr[15:0], last_addr[15:0]);
            end
        end
        inject_fail <= 1'b1;
        launch(rows[0]);
        wait_done();
        chk("verify any error", 16'h0082, {8'h00, rd_val[7:0]});
        inject_uncorr <= 1'b1;
        launch(rows[1]);
        wait_done();
        chk("verify uncorrectable", 16'h0083, {8'h00, rd_val[7:0]});
        inject_fail <= 1'b0;
        inject_uncorr <= 1'b0;
        wr(nvm_seq_pkg::ADDR_IRQ_MSK, 16'h0003);
        rd(nvm_seq_pkg::ADDR_IRQ_ST, rd_val);
        launch(rows[3]);
        wait_done();
        tick();
        chk_bit("irq raised", 1'b1, irq);
        rd(nvm_seq_pkg::ADDR_IRQ_ST, rd_val);
        chk("irq status", 16'h0003, rd_val);
        tick();
        chk_bit("irq cleared", 1'b0, irq);
        wr(nvm_seq_pkg::ADDR_IRQ_MSK, 16'h0000);
        launch(rows[0]);
        wait_done();
        tick();
        chk_bit("irq masked", 1'b0, irq);
        rd(nvm_seq_pkg::ADDR_IRQ_ST, rd_val);
        chk("masked irq status", 16'h0001, rd_val);
        wr(nvm_seq_pkg::ADDR_CONFIG, 16'h0080);
        tick();
        chk_bit("command irq", 1'b1, command_irq);
        launch(rows[0]);
        stop_request <= 1'b1;
        tick();
        tick();
        chk_bit("command irq busy", 1'b0, command_irq);
        chk_bit("stop held off", 1'b0, stop_ack);
        wait_done();
        tick();
        chk_bit("stop granted", 1'b1, stop_ack);
        chk_bit("command irq again", 1'b1, command_irq);
        stop_request <= 1'b0;
        wr(nvm_seq_pkg::ADDR_FAULT, 16'h0001);
        wr(nvm_seq_pkg::ADDR_CONFIG, 16'h0010);
        tick();
        chk_bit("error irq", 1'b1, error_irq);
        chk_bit("command irq off", 1'b0, command_irq);
        wr(nvm_seq_pkg::ADDR_FAULT, 16'h0000);
        tick();
        chk_bit("error irq off", 1'b0, error_irq);
        rd(4'hf, rd_val);
        chk("unmapped read", 16'h0000, rd_val);
        stop_test();
    end
endmodule
